/* logic/dtc_pkg.sv */
`default_nettype none
package dtc_pkg;

  // Oscillator periods per machine cycle
  localparam int unsigned OSC_PER_MCYCLE = 12;
  localparam logic [3:0]  MCYC_LAST      = 4'(OSC_PER_MCYCLE - 1);

  // Register indexes; byte address is four times the index
  localparam int unsigned ADDR_LSB     = 2;
  localparam logic [9:0]  IDX_CTRL     = 10'h088;
  localparam logic [9:0]  IDX_MODE     = 10'h089;
  localparam logic [9:0]  IDX_CNT0_LO  = 10'h08a;
  localparam logic [9:0]  IDX_CNT1_LO  = 10'h08b;
  localparam logic [9:0]  IDX_CNT0_HI  = 10'h08c;
  localparam logic [9:0]  IDX_CNT1_HI  = 10'h08d;
  localparam logic [9:0]  IDX_IRQ_STAT = 10'h090;
  localparam logic [9:0]  IDX_IRQ_MASK = 10'h091;

  // Control register fields
  localparam int unsigned CTRL_RUN0 = 4;
  localparam int unsigned CTRL_OVF0 = 5;
  localparam int unsigned CTRL_RUN1 = 6;
  localparam int unsigned CTRL_OVF1 = 7;

  // Mode register: one nibble per timer {gate, ctsel, mode[1:0]}
  localparam int unsigned MODE_CFG0_LSB = 0;
  localparam int unsigned MODE_CFG1_LSB = 4;
  localparam int unsigned MODE_GATE0    = 3;
  localparam int unsigned MODE_GATE1    = 7;

  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [7:0]  CNT_RST  = 8'h00;
  localparam logic [1:0]  IRQ_RST  = 2'h0;

  // Mode 0 prescaler width inside the low byte
  localparam int unsigned PRESC_BITS = 5;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DTC_M13   = 2'b00,
    DTC_M16   = 2'b01,
    DTC_M8R   = 2'b10,
    DTC_SPLIT = 2'b11
  } dtc_mode_t;

  typedef struct packed {
    logic      gate;
    logic      ctsel;
    dtc_mode_t mode;
  } dtc_cfg_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
  } dtc_step_t;

endpackage
`default_nettype wire

/* logic/dtc_top.sv */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Counter advances only while its run bit set, except timer one while timer zero is in mode 3
// - Overflow sets flag; interrupt vectoring clears it
// - Gate set requires interrupt pin high too
// - Counter select picks pin edges or cycles
// - Two-bit mode field selects operating mode
// - Mode 0 counts thirteen bits, upper three ignored
// - Mode 0 rollover to zero sets overflow
// - Setting run bit leaves counter contents alone
// - Gate bits at mode bits seven and three
// - Mode 1 counts all sixteen bits
// - Mode 2 reloads low byte from high byte
// - Timer one in mode 3 holds count
// - Timer zero mode 3 low byte own controls
// - Split high byte uses timer one controls
// - Timer one started by leaving mode 3
// - Timer function counts once per machine cycle
// - Pin sampled per cycle, falling sample counts
module dtc_top (
  // Clock and reset
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  // AXI4-Lite write address
  input  wire  logic [31:0] s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [31:0] s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // Count and gate pins
  input  wire  logic        count_input_zero,
  input  wire  logic        count_input_one,
  input  wire  logic        ext_irq_pin_zero,
  input  wire  logic        ext_irq_pin_one,
  // Interrupt controller side
  input  wire  logic        vec_ack_zero,
  input  wire  logic        vec_ack_one,
  output logic [1:0]        ovf_req,
  output logic              irq
);

  function automatic dtc_pkg::dtc_step_t tmr_step(
    input dtc_pkg::dtc_mode_t m,
    input logic [7:0]         lo,
    input logic [7:0]         hi
  );
    dtc_pkg::dtc_step_t s;
    logic [12:0]        c13;
    logic [15:0]        c16;
    s.lo  = lo;
    s.hi  = hi;
    s.ovf = 1'b0;
    c13   = {hi, lo[dtc_pkg::PRESC_BITS-1:0]} + 13'h0001;
    c16   = {hi, lo} + 16'h0001;
    unique case (m)
      dtc_pkg::DTC_M13: begin
        s.hi  = c13[12:5];
        s.lo  = {lo[7:5], c13[4:0]};
        s.ovf = (c13 == 13'h0000);
      end
      dtc_pkg::DTC_M16: begin
        s.hi  = c16[15:8];
        s.lo  = c16[7:0];
        s.ovf = (c16 == 16'h0000);
      end
      dtc_pkg::DTC_M8R: begin
        s.ovf = (lo == 8'hff);
        s.lo  = s.ovf ? hi : lo + 8'h01;
      end
      // low byte as its own 8-bit counter
      dtc_pkg::DTC_SPLIT: begin
        s.lo  = lo + 8'h01;
        s.ovf = (lo == 8'hff);
      end
    endcase
    return s;
  endfunction

  // Registers
  logic [7:0]          ctrl_q;
  logic [7:0]          ctrl_d;
  logic [7:0]          mode_q;
  logic [7:0]          cnt_lo_q [2];
  logic [7:0]          cnt_lo_d [2];
  logic [7:0]          cnt_hi_q [2];
  logic [7:0]          cnt_hi_d [2];
  logic [1:0]          irq_stat_q;
  logic [1:0]          irq_mask_q;

  // Pin synchronisers and samples
  logic [1:0]          cnt_meta_q;
  logic [1:0]          cnt_sync_q;
  logic [1:0]          cnt_prev_q;
  logic [1:0]          gate_meta_q;
  logic [1:0]          gate_sync_q;
  logic [3:0]          mcyc_cnt_q;
  logic                mcyc_tick;

  // Per-timer control
  dtc_pkg::dtc_cfg_t   cfg [2];
  dtc_pkg::dtc_step_t  step [2];
  logic [1:0]          run;
  logic [1:0]          fall;
  logic [1:0]          inc;
  logic [1:0]          ovf_evt;
  logic                split0;
  logic                hi0_inc;

  // Bus state
  logic                aw_have_q;
  logic                w_have_q;
  logic [9:0]          wr_idx_q;
  logic [7:0]          wr_data_q;
  logic                wr_strb_q;
  logic                wr_fire;
  logic                wr_hit;
  logic [9:0]          rd_idx;
  logic [7:0]          rd_byte;
  logic                rd_hit;

  // machine cycle enable, one pulse per twelve clocks
  assign mcyc_tick = (mcyc_cnt_q == dtc_pkg::MCYC_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcyc_cnt_q <= 4'h0;
    end else if (mcyc_tick) begin
      mcyc_cnt_q <= 4'h0;
    end else begin
      mcyc_cnt_q <= mcyc_cnt_q + 4'h1;
    end
  end

  // Pins cross in through two flops before any logic looks at them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_meta_q  <= 2'h0;
      cnt_sync_q  <= 2'h0;
      gate_meta_q <= 2'h0;
      gate_sync_q <= 2'h0;
    end else begin
      cnt_meta_q  <= {count_input_one, count_input_zero};
      cnt_sync_q  <= cnt_meta_q;
      gate_meta_q <= {ext_irq_pin_one, ext_irq_pin_zero};
      gate_sync_q <= gate_meta_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_prev_q <= 2'h0;
    end else if (mcyc_tick) begin
      cnt_prev_q <= cnt_sync_q;
    end
  end

  // gate bits sit at the top of each nibble
  assign cfg[0]  = dtc_pkg::dtc_cfg_t'(mode_q[dtc_pkg::MODE_CFG0_LSB +: 4]);
  assign cfg[1]  = dtc_pkg::dtc_cfg_t'(mode_q[dtc_pkg::MODE_CFG1_LSB +: 4]);
  assign split0  = (cfg[0].mode == dtc_pkg::DTC_SPLIT);
  assign run[0]  = ctrl_q[dtc_pkg::CTRL_RUN0];
  // while split, timer one runs unless parked in mode 3
  assign run[1]  = split0 ? 1'b1 : ctrl_q[dtc_pkg::CTRL_RUN1];
  // split high byte counts cycles on the second run bit
  assign hi0_inc = split0 & ctrl_q[dtc_pkg::CTRL_RUN1] & mcyc_tick;

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    logic cnt_en;
    logic src;
    // high sample then low sample counts once
    assign fall[i] = mcyc_tick & cnt_prev_q[i] & ~cnt_sync_q[i];
    assign cnt_en  = run[i] & (~cfg[i].gate | gate_sync_q[i]);
    assign src     = cfg[i].ctsel ? fall[i] : mcyc_tick;
    if (i == 1) begin : g_hold
      assign inc[i] = cnt_en & src & (cfg[i].mode != dtc_pkg::DTC_SPLIT);
    end else begin : g_run
      assign inc[i] = cnt_en & src;
    end
    assign step[i] = tmr_step(cfg[i].mode, cnt_lo_q[i], cnt_hi_q[i]);
  end

  assign ovf_evt[0] = inc[0] & step[0].ovf;
  // split high byte owns the second flag
  // timer one overflow raises no flag while split
  assign ovf_evt[1] = split0 ? (hi0_inc & (cnt_hi_q[0] == 8'hff))
                             : (inc[1] & step[1].ovf);

  // Bus write lands here, after address and data both arrived
  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid & wr_strb_q;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cnt_lo_d[i] = cnt_lo_q[i];
      cnt_hi_d[i] = cnt_hi_q[i];
      if (inc[i]) begin
        cnt_lo_d[i] = step[i].lo;
        if (!(i == 0 && split0)) begin
          cnt_hi_d[i] = step[i].hi;
        end
      end
    end
    if (hi0_inc) begin
      cnt_hi_d[0] = cnt_hi_q[0] + 8'h01;
    end
    // Software write beats a count in the same cycle
    for (int i = 0; i < 2; i++) begin
      if (wr_fire && wr_idx_q == dtc_pkg::IDX_CNT0_LO + 10'(i)) begin
        cnt_lo_d[i] = wr_data_q;
      end
      if (wr_fire && wr_idx_q == dtc_pkg::IDX_CNT0_HI + 10'(i)) begin
        cnt_hi_d[i] = wr_data_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2; i++) begin
        cnt_lo_q[i] <= dtc_pkg::CNT_RST;
        cnt_hi_q[i] <= dtc_pkg::CNT_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        cnt_lo_q[i] <= cnt_lo_d[i];
        cnt_hi_q[i] <= cnt_hi_d[i];
      end
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    // run bits are plain storage, counters untouched
    if (wr_fire && wr_idx_q == dtc_pkg::IDX_CTRL) begin
      ctrl_d[dtc_pkg::CTRL_RUN0] = wr_data_q[dtc_pkg::CTRL_RUN0];
      ctrl_d[dtc_pkg::CTRL_RUN1] = wr_data_q[dtc_pkg::CTRL_RUN1];
      ctrl_d[dtc_pkg::CTRL_OVF0] = wr_data_q[dtc_pkg::CTRL_OVF0];
      ctrl_d[dtc_pkg::CTRL_OVF1] = wr_data_q[dtc_pkg::CTRL_OVF1];
    end
    // vectoring clears, overflow sets and wins
    ctrl_d[dtc_pkg::CTRL_OVF0] = ovf_evt[0]
      | (ctrl_d[dtc_pkg::CTRL_OVF0] & ~vec_ack_zero);
    ctrl_d[dtc_pkg::CTRL_OVF1] = ovf_evt[1]
      | (ctrl_d[dtc_pkg::CTRL_OVF1] & ~vec_ack_one);
    // Low nibble belongs to the external interrupt logic
    ctrl_d[3:0] = 4'h0;
  end

  // control, mode and interrupt state cleared at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= dtc_pkg::CTRL_RST;
      mode_q <= dtc_pkg::MODE_RST;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_fire && wr_idx_q == dtc_pkg::IDX_MODE) begin
        mode_q <= wr_data_q;
      end
    end
  end

  // Sticky event bits: write one clears, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= dtc_pkg::IRQ_RST;
      irq_mask_q <= dtc_pkg::IRQ_RST;
      irq        <= 1'b0;
      ovf_req    <= 2'h0;
    end else begin
      if (wr_fire && wr_idx_q == dtc_pkg::IDX_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~wr_data_q[1:0]) | ovf_evt;
      end else begin
        irq_stat_q <= irq_stat_q | ovf_evt;
      end
      if (wr_fire && wr_idx_q == dtc_pkg::IDX_IRQ_MASK) begin
        irq_mask_q <= wr_data_q[1:0];
      end
      // One cycle behind the status bits, in exchange for a clean flop
      irq     <= |(irq_stat_q & irq_mask_q);
      ovf_req <= {ctrl_q[dtc_pkg::CTRL_OVF1], ctrl_q[dtc_pkg::CTRL_OVF0]};
    end
  end

  // Write channels are taken independently, answered once both are in
  assign wr_hit = (wr_idx_q == dtc_pkg::IDX_CTRL)
                | (wr_idx_q == dtc_pkg::IDX_MODE)
                | (wr_idx_q >= dtc_pkg::IDX_CNT0_LO
                   && wr_idx_q <= dtc_pkg::IDX_CNT1_HI)
                | (wr_idx_q == dtc_pkg::IDX_IRQ_STAT)
                | (wr_idx_q == dtc_pkg::IDX_IRQ_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      wr_idx_q      <= 10'h000;
      wr_data_q     <= 8'h00;
      wr_strb_q     <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dtc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_idx_q      <= s_axi_awaddr[dtc_pkg::ADDR_LSB +: 10];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data_q    <= s_axi_wdata[7:0];
        wr_strb_q    <= s_axi_wstrb[0];
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign rd_idx = s_axi_araddr[dtc_pkg::ADDR_LSB +: 10];

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (rd_idx)
      dtc_pkg::IDX_CTRL:     rd_byte = ctrl_q;
      dtc_pkg::IDX_MODE:     rd_byte = mode_q;
      dtc_pkg::IDX_CNT0_LO:  rd_byte = cnt_lo_q[0];
      dtc_pkg::IDX_CNT1_LO:  rd_byte = cnt_lo_q[1];
      dtc_pkg::IDX_CNT0_HI:  rd_byte = cnt_hi_q[0];
      dtc_pkg::IDX_CNT1_HI:  rd_byte = cnt_hi_q[1];
      dtc_pkg::IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat_q};
      dtc_pkg::IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_q};
      default:               rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= dtc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_byte};
        s_axi_rresp   <= rd_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // dtc_top

`default_nettype wire

/* verification/dtc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dtc_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  // Read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // Timer side
  input wire logic [1:0]  ovf_req,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ctrl_rd_q;
  logic wmap_q;
  function automatic logic mapped(input logic [31:0] a);
    return a[11:2] inside {dtc_pkg::IDX_CTRL, dtc_pkg::IDX_MODE,
      dtc_pkg::IDX_CNT0_LO, dtc_pkg::IDX_CNT1_LO, dtc_pkg::IDX_CNT0_HI,
      dtc_pkg::IDX_CNT1_HI, dtc_pkg::IDX_IRQ_STAT, dtc_pkg::IDX_IRQ_MASK};
  endfunction
  // Remember what the open transfers aimed at
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ctrl_rd_q <= s_axi_araddr[11:2] == dtc_pkg::IDX_CTRL;
    end
  end
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      wmap_q <= mapped(s_axi_awaddr);
    end
  end
  reset_quiet_a:
    assert property ($rose(aresetn) |-> ovf_req == 2'h0 && !irq)
    else $error("outputs busy after reset");
  flag_mirror_a:
    assert property ($rose(s_axi_rvalid) && ctrl_rd_q |->
      s_axi_rdata[7] == ovf_req[1] && s_axi_rdata[5] == ovf_req[0])
    else $error("flag outputs differ from control read");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  read_decode_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rresp ==
      (mapped(s_axi_araddr) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR))
    else $error("read response code wrong");
  rdata_upper_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer not on time");
  write_busy_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> (!s_axi_awready && !s_axi_wready) [*2])
    else $error("write accepted while busy");
  write_decode_a:
    assert property (s_axi_bvalid |-> s_axi_bresp ==
      (wmap_q ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR))
    else $error("write response code wrong");
  cover property (s_axi_bvalid && s_axi_bresp == dtc_pkg::RESP_SLVERR);
  cover property (irq);
  cover property (ovf_req[1]);
endmodule // dtc_checker

bind dtc_top dtc_checker u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .ovf_req, .irq
);
`default_nettype wire

/* verification/dtc_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dtc_pins_model (
  // Clock
  input  wire logic aclk,
  // Pins toward the timers
  output logic      count_input_zero,
  output logic      count_input_one,
  output logic      ext_irq_pin_zero,
  output logic      ext_irq_pin_one
);
  initial begin
    count_input_zero = 1'b1;
    count_input_one  = 1'b1;
    ext_irq_pin_zero = 1'b0;
    ext_irq_pin_one  = 1'b0;
  end
  task automatic gate(input logic g0, input logic g1);
    @(posedge aclk);
    ext_irq_pin_zero <= g0;
    ext_irq_pin_one  <= g1;
  endtask
  // each level held for hold clocks, giving n falling edges per call
  task automatic pulses(input bit ch, input int n, input int hold);
    repeat (2 * n) begin
      repeat (hold) @(posedge aclk);
      if (ch) count_input_one <= !count_input_one;
      else count_input_zero <= !count_input_zero;
    end
    repeat (hold) @(posedge aclk);
  endtask
endmodule // dtc_pins_model
`default_nettype wire

/* verification/dtc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dtc_top_tb_top;
  localparam logic [9:0] CT = dtc_pkg::IDX_CTRL;
  localparam logic [9:0] MD = dtc_pkg::IDX_MODE;
  localparam logic [9:0] L0 = dtc_pkg::IDX_CNT0_LO;
  localparam logic [9:0] L1 = dtc_pkg::IDX_CNT1_LO;
  localparam logic [9:0] H0 = dtc_pkg::IDX_CNT0_HI;
  localparam logic [9:0] H1 = dtc_pkg::IDX_CNT1_HI;
  localparam logic [9:0] ST = dtc_pkg::IDX_IRQ_STAT;
  localparam logic [9:0] MK = dtc_pkg::IDX_IRQ_MASK;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, vack0 = 1'b0, vack1 = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, ovf_req, rsp;
  logic        cin0, cin1, gp0, gp1;
  int          n_errors = 0, compares = 0, cyc = 0, t1 = 0;
  logic [9:0]  regs [8] = '{CT, MD, L0, L1, H0, H1, ST, MK};

  always #20 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  dtc_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .count_input_zero(cin0), .count_input_one(cin1),
    .ext_irq_pin_zero(gp0), .ext_irq_pin_one(gp1),
    .vec_ack_zero(vack0), .vec_ack_one(vack1), .ovf_req(ovf_req), .irq(irq)
  );
  dtc_pins_model u_pins (
    .aclk(aclk), .count_input_zero(cin0), .count_input_one(cin1),
    .ext_irq_pin_zero(gp0), .ext_irq_pin_one(gp1)
  );

  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Every wait is bounded so a stuck handshake ends the run
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    awaddr  <= {20'h0, ix, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      step(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    do step(n); while (!bvalid);
    rsp = bresp;
  endtask
  task automatic rd(input logic [9:0] ix, input logic [7:0] e);
    int n;
    n = 0;
    araddr  <= {20'h0, ix, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do step(n); while (!arready);
    arvalid <= 1'b0;
    do step(n); while (!rvalid);
    rsp = rresp;
    chk(rdata, {24'h0, e});
  endtask
  // Both writes take equal time, so the enabled span is exactly k ticks
  task automatic run(input logic [7:0] on, input logic [7:0] off,
                     input int k);
    int t0;
    t0 = cyc;
    wr(CT, on);
    while (cyc < t0 + 12 * k) @(posedge aclk);
    wr(CT, off);
  endtask
  task automatic ack(input bit ch);
    @(posedge aclk);
    vack0 <= !ch;
    vack1 <= ch;
    @(posedge aclk);
    vack0 <= 1'b0;
    vack1 <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(10'h08e, 8'h00);
    chk(rsp, dtc_pkg::RESP_SLVERR);
    wr(10'h08e, 8'hff);
    chk(rsp, dtc_pkg::RESP_SLVERR);
    wr(MD, 8'ha5);
    rd(MD, 8'ha5);
    wstrb <= 4'h0;
    wr(MD, 8'h00);
    wstrb <= 4'hf;
    rd(MD, 8'ha5);
    wr(CT, 8'h0f);
    rd(CT, 8'h00);
    wr(L0, 8'hfe);
    wr(H0, 8'h12);
    wr(MD, 8'h01);
    run(8'h10, 8'h00, 5);
    rd(L0, 8'h03);
    rd(H0, 8'h13);
    repeat (48) @(posedge aclk);
    rd(L0, 8'h03);
    wr(L0, 8'hfe);
    wr(H0, 8'hff);
    wr(MD, 8'h00);
    run(8'h10, 8'h00, 3);
    rd(H0, 8'h00);
    rd(L0, 8'he1);
    rd(ST, 8'h01);
    wr(ST, 8'h01);
    wr(L0, 8'hfe);
    wr(H0, 8'hc0);
    wr(MD, 8'h02);
    wr(MK, 8'h01);
    run(8'h10, 8'h20, 4);
    rd(L0, 8'hc2);
    rd(H0, 8'hc0);
    rd(CT, 8'h20);
    chk(irq, 1'b1);
    ack(1'b0);
    chk(ovf_req, 2'b00);
    rd(CT, 8'h00);
    wr(MK, 8'h00);
    // Interrupt output trails the mask by one clock
    @(posedge aclk);
    chk(irq, 1'b0);
    wr(MK, 8'h01);
    wr(ST, 8'h01);
    @(posedge aclk);
    chk(irq, 1'b0);
    rd(ST, 8'h00);
    wr(L0, 8'h00);
    wr(MD, 8'h09);
    run(8'h10, 8'h00, 4);
    rd(L0, 8'h00);
    u_pins.gate(1'b1, 1'b0);
    run(8'h10, 8'h00, 4);
    rd(L0, 8'h04);
    u_pins.gate(1'b0, 1'b0);
    wr(L0, 8'h00);
    wr(MD, 8'h05);
    wr(CT, 8'h10);
    u_pins.pulses(1'b0, 2, 24);
    u_pins.pulses(1'b0, 1, 60);
    wr(CT, 8'h00);
    rd(L0, 8'h03);
    wr(L1, 8'h00);
    wr(MD, 8'h10);
    run(8'h40, 8'h00, 2);
    rd(L1, 8'h02);
    wr(MD, 8'h90);
    run(8'h40, 8'h00, 2);
    rd(L1, 8'h02);
    wr(MD, 8'h30);
    run(8'h40, 8'h00, 3);
    rd(L1, 8'h02);
    wr(H0, 8'hff);
    wr(MD, 8'h33);
    run(8'h50, 8'h80, 2);
    rd(H0, 8'h01);
    rd(L0, 8'h05);
    rd(L1, 8'h02);
    rd(ST, 8'h02);
    ack(1'b1);
    chk(ovf_req, 2'b00);
    rd(CT, 8'h00);
    // Split timer zero lets timer one run with its run bit clear
    t1 = cyc;
    wr(MD, 8'h13);
    while (cyc < t1 + 24) @(posedge aclk);
    wr(MD, 8'h33);
    rd(L1, 8'h04);
    stop_test();
  end
endmodule // dtc_top_tb_top
`default_nettype wire
